// ===== logic/wdt_pkg.sv
// Purpose: shared constants and types of the windowed watchdog
// Assumes: 32-bit AHB-Lite register window, word accesses only
// Notes:   configuration byte is held in a writable register here
package wdt_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  OFS_RESET_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_CONFIG         = 8'h04;
    localparam logic [7:0]  OFS_COUNT          = 8'h08;
    localparam int          BIT_SOFT_EN        = 5;
    localparam int          BIT_TIMEOUT        = 4;
    localparam int          BIT_SLEEP          = 3;
    localparam int          BIT_IDLE           = 2;
    localparam int          CFG_HWEN_HI        = 7;
    localparam int          CFG_WINDOW_DISABLE_BIT         = 6;
    localparam int          CFG_HWEN_LO        = 5;
    localparam int          CFG_PSA            = 4;
    localparam int          CFG_PS_LSB         = 0;
    localparam int          CFG_PS_W           = 4;
    localparam logic [7:0]  CONFIG_RESET       = 8'hdf;
    localparam logic [7:0]  RESET_CTRL_RESET   = 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int          PRESCALE_SHORT_BITS = 5;
    localparam int          PRESCALE_LONG_BITS  = 7;
    localparam int          POSTSCALE_MAX_LOG2  = 15;
    localparam int          COUNT_W_DEFAULT     = PRESCALE_LONG_BITS + POSTSCALE_MAX_LOG2;
    localparam int          LOW_POWER_RC_OSC_NOMINAL_HZ     = 31000;
    localparam int          BASE_TIMEOUT_SHORT_MS = 1;
    localparam int          BASE_TIMEOUT_LONG_MS  = 4;
    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        HW_OFF    = 2'b00,
        HW_ACTIVE = 2'b01,
        HW_SOFT   = 2'b10,
        HW_ALWAYS = 2'b11
    } hw_enable_t;
    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_IDLE  = 2'b01,
        PWR_SLEEP = 2'b10
    } power_state_t;
endpackage

// ===== logic/wdt_count_if.sv
// Purpose: carrier between watchdog control and its tick counter
// Assumes: both ends on core_clk
// Notes:   expire is combinational from the counter
`timescale 1ns/100ps
interface wdt_count_if #(
    parameter int COUNT_W = 22
);
    logic               tick;
    logic               clear;
    logic               run;
    logic               longPrescale;
    logic [3:0]         postSel;
    logic [COUNT_W-1:0] count;
    logic               windowOpen;
    logic               expire;
    modport ctrl (output tick, clear, run, longPrescale, postSel,
                  input  count, windowOpen, expire);
    modport cnt  (input  tick, clear, run, longPrescale, postSel,
                  output count, windowOpen, expire);
endinterface

// ===== logic/wdt_counter.sv
// Purpose: prescaler and postscaler as one tick counter with window compare
// Assumes: tick is a one-cycle pulse per oscillator period
// Notes:   low bits act as prescaler, high bits as postscaler
`timescale 1ns/100ps
module wdt_counter
    import wdt_pkg::*;
#(
    parameter int COUNT_W = COUNT_W_DEFAULT
) (
    input wire logic    core_clk,
    input wire logic    reset_n,
    wdt_count_if.cnt    cnt
);
    localparam int LW = COUNT_W + 1;
    localparam logic [LW-1:0]      ONE_W  = {{(LW-1){1'b0}}, 1'b1};
    localparam logic [COUNT_W-1:0] ONE_C  = {{(COUNT_W-1){1'b0}}, 1'b1};

    if (COUNT_W < PRESCALE_LONG_BITS + POSTSCALE_MAX_LOG2) begin : g_check
        $error("counter too narrow for the longest period");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0]    shiftAmt;
    logic [LW-1:0] limit;
    logic [LW-1:0] terminal;
    logic [LW-1:0] windowStart;
    logic [LW-1:0] countWide;
    logic          atTerminal;

    // total period is prescale ratio times postscale ratio
    assign shiftAmt    = (cnt.longPrescale ? 5'(PRESCALE_LONG_BITS)
                                           : 5'(PRESCALE_SHORT_BITS))
                         + {1'b0, cnt.postSel};
    assign limit       = ONE_W << shiftAmt;
    assign terminal    = limit - ONE_W;
    assign windowStart = limit - (limit >> 2);
    assign countWide   = {1'b0, cnt.count};
    assign atTerminal  = (countWide == terminal);

    assign cnt.windowOpen = (countWide >= windowStart);
    // expire ignores clear; control gates it with outside clears only, so no loop
    assign cnt.expire     = cnt.run && cnt.tick && atTerminal;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt.count <= '0;
        end else if (cnt.clear) begin
            cnt.count <= '0;
        end else if (cnt.run && cnt.tick) begin
            cnt.count <= atTerminal ? '0 : cnt.count + ONE_C;
        end
    end
endmodule

// ===== logic/windowed_watchdog_timer.sv
// Purpose: windowed watchdog with AHB-Lite register access
// Assumes: instruction and power events are one-cycle pulses on core_clk
// Notes:   oscillator pin is synchronised; nothing else crosses domains
`timescale 1ns/100ps

// Notes on behaviour
// - oscillator runs whenever watchdog is running
// - prescaler is 5-bit or 7-bit stage
// - base period 1 ms or 4 ms
// - postscaler offers 16 power-of-two ratios
// - reset and clock switch clear counter
// - power-save entry and exit clear counter
// - clear instruction in run clears counter
// - always-enabled timeout in power-save wakes device
// - timeout flag sticky until software clears
// - in window mode, clear accepted only in final quarter
// - early clear in window mode resets
// - window mode when window-disable bit zero
// - field 11 enables regardless of software
// - field 10 follows software enable bit
// - device reset clears software enable bit
// - field 01 stops in sleep, ignores software
// - field 00 disables, ignores software
// - prescale bit one selects 1:128
// - clear while fully disabled never resets
module windowed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int COUNT_W = COUNT_W_DEFAULT
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        lowPowerRcOsc,
    output logic             lprcEnable,
    input  wire logic        clearWatchdogInstr,
    input  wire logic        enterSleep,
    input  wire logic        enterIdle,
    input  wire logic        exitPowerSave,
    input  wire logic        clockSwitchDone,
    output logic             watchdogReset,
    output logic             watchdogWake
);
    ////////////////////////////////////////////////////////////////////////////////
    // count is read back in one bus word

    if (COUNT_W < COUNT_W_DEFAULT || COUNT_W > 32) begin : g_width_check
        $error("count width must lie between the default and one bus word");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic hitReg(input logic [31:0] addr, input logic [7:0] ofs);
        hitReg = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic         rcSync1;
    logic         rcSync2;
    logic         rcSync3;
    logic         softEnable;
    logic         timeoutFlag;
    logic         sleepFlag;
    logic         idleFlag;
    logic [7:0]   configByte;
    power_state_t powerState;
    power_state_t next_powerState;
    logic         wrPending;
    logic [31:0]  wrAddr;

    wdt_count_if #(.COUNT_W(COUNT_W)) countBus ();

    wdt_counter #(.COUNT_W(COUNT_W)) u_counter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .cnt      (countBus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator edge; first flop feeds only the second

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rcSync1 <= 1'b0;
            rcSync2 <= 1'b0;
            rcSync3 <= 1'b0;
        end else begin
            rcSync1 <= lowPowerRcOsc;
            rcSync2 <= rcSync1;
            rcSync3 <= rcSync2;
        end
    end

    wire rcTick = rcSync2 && !rcSync3;

    ////////////////////////////////////////////////////////////////////////////////
    // enable and mode decode

    hw_enable_t hwEnable;
    wire        inRun;
    wire        running;
    wire        windowMode;
    wire        timeoutEvt;
    wire        earlyClear;
    wire        fireReset;
    wire        fireWake;
    wire        runClear;
    wire        extClear;

    assign hwEnable   = hw_enable_t'({configByte[CFG_HWEN_HI], configByte[CFG_HWEN_LO]});
    assign inRun      = (powerState == PWR_RUN);
    assign running    = (hwEnable == HW_ALWAYS)
                     || (hwEnable == HW_SOFT && softEnable)
                     || (hwEnable == HW_ACTIVE && powerState != PWR_SLEEP);
    assign windowMode = !configByte[CFG_WINDOW_DISABLE_BIT];
    assign runClear   = clearWatchdogInstr && inRun;
    assign extClear   = runClear || enterSleep || enterIdle
                     || exitPowerSave || clockSwitchDone;
    // outside clears win over a same-cycle expiry; own resets must not gate it
    assign timeoutEvt = countBus.expire && !extClear;
    // a fully disabled watchdog never turns a clear into a reset
    assign earlyClear = runClear && windowMode && running && !countBus.windowOpen;
    assign fireReset  = (timeoutEvt && inRun) || earlyClear;
    assign fireWake   = timeoutEvt && !inRun;

    assign lprcEnable = running;

    assign countBus.tick         = rcTick;
    assign countBus.run          = running;
    assign countBus.longPrescale = configByte[CFG_PSA];
    assign countBus.postSel      = configByte[CFG_PS_LSB +: CFG_PS_W];
    // own reset and wake count as device reset and power-save exit
    assign countBus.clear        = extClear
                                || fireReset || fireWake;

    ////////////////////////////////////////////////////////////////////////////////
    // power state follows the core's power-save events

    always_comb begin
        next_powerState = powerState;
        unique case (powerState)
            PWR_RUN: begin
                if (enterSleep) begin
                    next_powerState = PWR_SLEEP;
                end else if (enterIdle) begin
                    next_powerState = PWR_IDLE;
                end
            end
            PWR_IDLE, PWR_SLEEP: begin
                if (exitPowerSave || fireWake) begin
                    next_powerState = PWR_RUN;
                end
            end
            default: begin
                next_powerState = PWR_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait, always OKAY

    wire addrPhase = hsel && htrans[1] && hready;
    wire wrRcon    = wrPending && hitReg(wrAddr, OFS_RESET_CTRL);
    wire wrConfig  = wrPending && hitReg(wrAddr, OFS_CONFIG);

    logic [31:0] readMux;
    always_comb begin
        readMux = 32'h00000000;
        if (hitReg(haddr, OFS_RESET_CTRL)) begin
            readMux[BIT_SOFT_EN] = softEnable;
            readMux[BIT_TIMEOUT] = timeoutFlag;
            readMux[BIT_SLEEP]   = sleepFlag;
            readMux[BIT_IDLE]    = idleFlag;
        end else if (hitReg(haddr, OFS_CONFIG)) begin
            readMux[7:0] = configByte;
        end else if (hitReg(haddr, OFS_COUNT)) begin
            readMux[COUNT_W-1:0] = countBus.count;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPending <= 1'b0;
            wrAddr    <= 32'h00000000;
            hrdata    <= 32'h00000000;
        end else begin
            wrPending <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr <= haddr;
            end
            if (addrPhase && !hwrite) begin
                hrdata <= readMux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status and control bits; hardware set wins over a software write

    wire next_softEnable  = fireReset ? 1'b0
                          : (wrRcon && hwEnable == HW_SOFT) ? hwdata[BIT_SOFT_EN]
                          : softEnable;
    wire next_timeoutFlag = (fireReset || fireWake)
                          || (wrRcon ? hwdata[BIT_TIMEOUT] : timeoutFlag);
    // only software lowers these after a wake
    wire next_sleepFlag   = (inRun && enterSleep)
                          || (wrRcon ? hwdata[BIT_SLEEP] : sleepFlag);
    wire next_idleFlag    = (inRun && !enterSleep && enterIdle)
                          || (wrRcon ? hwdata[BIT_IDLE] : idleFlag);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            softEnable  <= RESET_CTRL_RESET[BIT_SOFT_EN];
            timeoutFlag <= RESET_CTRL_RESET[BIT_TIMEOUT];
            sleepFlag   <= RESET_CTRL_RESET[BIT_SLEEP];
            idleFlag    <= RESET_CTRL_RESET[BIT_IDLE];
            configByte  <= CONFIG_RESET;
            powerState  <= PWR_RUN;
        end else begin
            softEnable  <= next_softEnable;
            timeoutFlag <= next_timeoutFlag;
            sleepFlag   <= next_sleepFlag;
            idleFlag    <= next_idleFlag;
            configByte  <= wrConfig ? hwdata[7:0] : configByte;
            powerState  <= next_powerState;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdogReset <= 1'b0;
            watchdogWake  <= 1'b0;
        end else begin
            watchdogReset <= fireReset;
            watchdogWake  <= fireWake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence sleepTimeout;
        (powerState != PWR_RUN) && timeoutEvt;
    endsequence

    sequence wokenClean;
        watchdogWake && !watchdogReset && (powerState == PWR_RUN);
    endsequence

    timeout_wakes_a: assert property (sleepTimeout |=> wokenClean)
        else $error("power-save timeout did not wake cleanly");

    flag_on_reset_a: assert property (watchdogReset |-> timeoutFlag)
        else $error("reset pulse without timeout flag");

    flag_sticky_a: assert property (timeoutFlag && !wrRcon |=> timeoutFlag)
        else $error("timeout flag dropped without software");

    early_clear_a: assert property (
        runClear && windowMode && running && !countBus.windowOpen |=> watchdogReset)
        else $error("early clear did not reset");

    window_clear_a: assert property (
        runClear && countBus.windowOpen && !timeoutEvt |=> !watchdogReset)
        else $error("clear in window caused reset");

    disabled_quiet_a: assert property (
        hwEnable == HW_OFF && !softEnable |=> !watchdogReset [*2])
        else $error("disabled watchdog produced reset");

    soft_locked_a: assert property (hwEnable != HW_SOFT && !fireReset |=> $stable(softEnable))
        else $error("software enable changed while locked");

    soft_cleared_a: assert property (watchdogReset |-> !softEnable)
        else $error("software enable survived watchdog reset");

    osc_follows_a: assert property (
        hwEnable == HW_ALWAYS |-> lprcEnable && countBus.run)
        else $error("oscillator off while always enabled");

    sleep_stop_a: assert property (
        hwEnable == HW_ACTIVE && powerState == PWR_SLEEP |-> !lprcEnable)
        else $error("watchdog ran in sleep with active-only setting");

    clear_zero_a: assert property (countBus.clear |=> countBus.count == '0)
        else $error("counter not cleared");

    tick_single_a: assert property (rcTick |=> !rcTick)
        else $error("oscillator tick longer than one cycle");

    clear_wins_a: assert property (extClear |-> !timeoutEvt)
        else $error("expiry taken in the same cycle as a clear");

    sequence runReset;
        watchdogReset && !watchdogWake;
    endsequence

    run_timeout_a: assert property (timeoutEvt && inRun |=> runReset)
        else $error("run timeout did not reset");

    wake_flag_a: assert property (watchdogWake |-> timeoutFlag && !watchdogReset)
        else $error("wake without timeout flag");

    soft_follows_a: assert property (hwEnable == HW_SOFT |-> running == softEnable)
        else $error("software-controlled watchdog ignores its enable bit");

    off_stopped_a: assert property (hwEnable == HW_OFF |-> !running && !lprcEnable)
        else $error("disabled watchdog still running");

    active_runs_a: assert property (
        hwEnable == HW_ACTIVE && powerState != PWR_SLEEP |-> running)
        else $error("active-only watchdog stopped outside sleep");

    std_clear_a: assert property (configByte[CFG_WINDOW_DISABLE_BIT] && runClear |=> !watchdogReset)
        else $error("clear caused reset outside window mode");

    sleep_kept_a: assert property (sleepFlag && !wrRcon |=> sleepFlag)
        else $error("sleep flag dropped without software");

    switch_clears_a: assert property (clockSwitchDone |=> countBus.count == '0)
        else $error("clock switch did not clear counter");

    sequence sleepRecorded;
        (powerState == PWR_SLEEP) && sleepFlag;
    endsequence

    enter_sleep_a: assert property (inRun && enterSleep |=> sleepRecorded)
        else $error("sleep entry not recorded");
endmodule

// ===== dv/windowed_watchdog_timer_bench.sv
// Purpose: self-checking bench for the windowed watchdog
// Assumes: oscillator pin toggles every 4 core cycles, one tick per 8 cycles
// Notes:   periods shortened through ps of 0 or 1 and the 1:32 prescaler, with one 1:128 case
`timescale 1ns/100ps
module windowed_watchdog_timer_bench;
    import wdt_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        low_power_rc_osc;
    } row_t;
    localparam int EV_CLR = 0;
    localparam int EV_SLP = 1;
    localparam int EV_IDL = 2;
    localparam int EV_EXIT = 3;
    localparam int EV_SW = 4;
    localparam int TICK = 8;
    logic        core_clk;
    logic        reset_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        lowPowerRcOsc = 1'b0;
    logic        lprcEnable;
    logic [4:0]  evt;
    logic        watchdogReset;
    logic        watchdogWake;
    logic [2:0]  oscDiv = 3'h0;
    logic [31:0] rd;
    logic        wake;
    int          n;
    int          nFail;
    int          checkCount;
    // field 11 rows keep long periods so no timeout lands mid-table
    row_t rows[11] = '{
        '{8'h04, 32'hf5, 32'hf5, 1'b1}, '{8'h00, 32'h20, 32'h00, 1'b1},
        '{8'h0c, 32'h55, 32'h00, 1'b1}, '{8'h04, 32'hdf, 32'hdf, 1'b0},
        '{8'h00, 32'h20, 32'h20, 1'b1}, '{8'h00, 32'h00, 32'h00, 1'b0},
        '{8'h04, 32'h1f, 32'h1f, 1'b0}, '{8'h00, 32'h20, 32'h00, 1'b0},
        '{8'h04, 32'h7f, 32'h7f, 1'b1}, '{8'h00, 32'h20, 32'h00, 1'b1},
        '{8'h04, 32'hff, 32'hff, 1'b1}};
    logic [7:0] cfgs[3] = '{8'he0, 8'he1, 8'hf0};
    int         ticks[3] = '{32 * TICK, 64 * TICK, 128 * TICK};
    assign hready = hreadyout;
    windowed_watchdog_timer #(.COUNT_W(22)) i_windowed_watchdog_timer (
        .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .lowPowerRcOsc(lowPowerRcOsc), .lprcEnable(lprcEnable),
        .clearWatchdogInstr(evt[EV_CLR]), .enterSleep(evt[EV_SLP]),
        .enterIdle(evt[EV_IDL]), .exitPowerSave(evt[EV_EXIT]),
        .clockSwitchDone(evt[EV_SW]), .watchdogReset(watchdogReset),
        .watchdogWake(watchdogWake));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        oscDiv <= oscDiv + 3'h1;
        lowPowerRcOsc <= oscDiv[2];
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic checkVal(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic checkRange(input string nm, input int lo, input int hi, input int got);
        checkCount++;
        if (got < lo || got > hi) begin
            nFail++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic readCheck(input string nm, input logic [7:0] a, input logic [31:0] exp);
        busXfer(1'b0, a, 32'h0);
        checkVal(nm, exp, rd);
    endtask
    task automatic countNearZero();
        busXfer(1'b0, OFS_COUNT, 32'h0);
        checkRange("count", 0, 1, $isunknown(rd) ? -1 : int'(rd));
    endtask
    task automatic pulse(input int idx);
        @(posedge core_clk);
        evt[idx] <= 1'b1;
        @(posedge core_clk);
        evt <= '0;
    endtask
    // looks first at the edge that just passed: a clear's reset shows right after it
    task automatic waitEvent();
        n = 0;
        #1;
        while (watchdogReset !== 1'b1 && watchdogWake !== 1'b1) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        wake = watchdogWake;
    endtask
    task automatic quiet(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c) begin
            #1;
            seen = seen | watchdogReset | watchdogWake;
            @(posedge core_clk);
        end
        checkVal("no event", 32'h0, {31'h0, seen});
    endtask
    task automatic resetPulse();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask
    task automatic complete_run();
        if (nFail == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, evt} = '0;
        nFail = 0;
        checkCount = 0;
        reset_n = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        checkVal("hresp", 32'h0, {31'h0, hresp});
        // reset config is field 10 with software enable low: stopped
        checkVal("low_power_rc_osc reset", 32'h0, {31'h0, lprcEnable});
        readCheck("config reset", OFS_CONFIG, {24'h0, CONFIG_RESET});
        readCheck("ctrl reset", OFS_RESET_CTRL, {24'h0, RESET_CTRL_RESET});
        foreach (rows[i]) begin
            busXfer(1'b1, rows[i].addr, rows[i].wdata);
            readCheck("table read", rows[i].addr, rows[i].rdata);
            checkVal("lprcEnable", {31'h0, rows[i].low_power_rc_osc}, {31'h0, lprcEnable});
        end
        // software enable lost on device reset
        busXfer(1'b1, OFS_CONFIG, 32'hdf);
        busXfer(1'b1, OFS_RESET_CTRL, 32'h20);
        resetPulse();
        readCheck("soft enable", OFS_RESET_CTRL, 32'h00);
        // period = prescale * postscale ticks, flag sticks
        foreach (cfgs[i]) begin
            busXfer(1'b1, OFS_CONFIG, {24'h0, cfgs[i]});
            busXfer(1'b1, OFS_RESET_CTRL, 32'h0);
            pulse(EV_CLR);
            waitEvent();
            checkRange("period", ticks[i] - 12, ticks[i] + 12, n);
            checkVal("run reset", 32'h0, {31'h0, wake});
            repeat (20) @(posedge core_clk);
            readCheck("flag", OFS_RESET_CTRL, 32'h10);
        end
        busXfer(1'b1, OFS_RESET_CTRL, 32'h0);
        readCheck("flag cleared", OFS_RESET_CTRL, 32'h0);
        // windowed clears; an early clear resets in the cycle after its edge
        busXfer(1'b1, OFS_CONFIG, 32'ha0);
        pulse(EV_SW);
        countNearZero();
        repeat (10) @(posedge core_clk);
        pulse(EV_CLR);
        waitEvent();
        checkRange("early clear", 0, 0, n);
        repeat (27 * TICK - n) @(posedge core_clk);
        pulse(EV_CLR);
        quiet(4);
        countNearZero();
        repeat (20 * TICK) @(posedge core_clk);
        pulse(EV_CLR);
        waitEvent();
        checkRange("edge clear", 0, 0, n);
        busXfer(1'b1, OFS_CONFIG, 32'h00);
        pulse(EV_CLR);
        quiet(6);
        // always-on timeout in power save wakes
        busXfer(1'b1, OFS_CONFIG, 32'he0);
        for (int s = 0; s < 2; s++) begin
            busXfer(1'b1, OFS_RESET_CTRL, 32'h0);
            pulse(s == 0 ? EV_SLP : EV_IDL);
            waitEvent();
            checkRange("sleep period", 32 * TICK - 12, 32 * TICK + 12, n);
            checkVal("wake", 32'h1, {31'h0, wake});
            readCheck("ps flags", OFS_RESET_CTRL, s == 0 ? 32'h18 : 32'h14);
            busXfer(1'b1, OFS_RESET_CTRL, 32'h0);
            readCheck("ps cleared", OFS_RESET_CTRL, 32'h0);
        end
        // active-only field stops in sleep, runs again after exit
        busXfer(1'b1, OFS_CONFIG, 32'h60);
        pulse(EV_SLP);
        repeat (2) @(posedge core_clk);
        checkVal("low_power_rc_osc sleep", 32'h0, {31'h0, lprcEnable});
        quiet(400);
        pulse(EV_EXIT);
        countNearZero();
        waitEvent();
        checkRange("after exit", 32 * TICK - 16, 32 * TICK + 12, n);
        checkVal("exit reset", 32'h0, {31'h0, wake});
        complete_run();
    end
    initial begin
        #1000000;
        nFail++;
        complete_run();
    end
endmodule
